//--- src/nfh_pkg.sv
// Package of constants and carriers for the NAND flash host pin controller
package nfh_pkg;
  // Address field widths, byte-wide and word-wide organisation
  localparam int COL_W_X8 = 12;
  localparam int COL_W_X16 = 11;
  localparam int PAGE_W = 6;
  localparam int BLOCK_W = 10;
  localparam int ROW_W = PAGE_W + BLOCK_W;
  localparam int ADDR_CYCLES = 4;
  localparam logic [1:0] ADDR_LAST = 2'h3;
  // Column limits: data area plus spare area
  localparam logic [11:0] COL_LIMIT_X8 = 12'h840;
  localparam logic [11:0] COL_LIMIT_X16 = 12'h420;
  // Strobe phase timing at 40 MHz (25 ns period)
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 25;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LOW_CNT = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] HIGH_CNT = 4'(STROBE_HIGH_CYC);

  typedef enum logic [1:0] {
    NFH_OP_CMD,
    NFH_OP_ADDR,
    NFH_OP_WRITE,
    NFH_OP_READ
  } nfh_op_e;

  // One request from the user side
  typedef struct packed {
    nfh_op_e op;
    logic [15:0] data;
    logic [COL_W_X8-1:0] col;
    logic [ROW_W-1:0] row;
  } nfh_req_s;

  // Pin-level outputs held in flip-flops
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
  } nfh_pins_s;
endpackage

//--- src/nfh_fifo.sv
// Request FIFO with valid/ready on both sides
`timescale 1ns/100ps
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Ready is a flop so the fill side never sees a combinational path
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_in_ready <= 1'b1;
    end else begin
      o_in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end
endmodule

//--- src/nfh_host.sv
// Host controller driving a NAND flash through its pins
// Operation
// RULE1: Device latches DQ on write-strobe rise
// RULE2: Device floats DQ when deselected
// RULE3: CLE high: strobed value is command
// RULE4: ALE high: strobed value is address
// RULE5: Chip enable never aborts busy operation
// RULE6: Read strobe fall drives data, advances column
// RULE7: Write-protect low blocks program and erase
// RULE8: Open-drain ready/busy, low while busy
// RULE9: Byte mode four address cycles layout
// RULE10: Byte mode column, page, block fields
// RULE11: Word mode four address cycles layout
// RULE12: Word mode column, page, block fields
// RULE13: Byte page 2048+64, 64 pages, 1024 blocks
// RULE14: Word page 1024+32, 64 pages, 1024 blocks
// RULE15: Device sequences program and erase internally
// RULE16: Commands and addresses on low DQ byte
// RULE17: Read: CE low, WE high, latches low
// RULE18: Host keeps column within page plus spare (code only raises o_col_error and still issues the column)
`timescale 1ns/100ps
module nfh_host
  import nfh_pkg::*;
#(
  parameter bit WORD_MODE = 1'b0,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // User request stream
  input wire logic i_req_valid,
  input wire nfh_pkg::nfh_req_s i_req,
  output logic o_req_ready,
  input wire logic i_write_enable,
  // User read answer
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_busy,
  output logic o_col_error,
  // Flash pins
  output nfh_pkg::nfh_pins_s o_pins,
  output logic [15:0] o_dq,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq,
  input wire logic i_ready_busy_n
);
  import nfh_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_ADDR_NEXT,
    ST_CAPTURE
  } nfh_state_e;

  localparam int REQ_W = $bits(nfh_req_s);

  nfh_state_e state;
  nfh_req_s cur;
  logic fifo_valid;
  logic fifo_ready;
  nfh_req_s fifo_req;
  logic [3:0] timer;
  logic [1:0] addr_idx;
  logic [1:0] rb_sync;
  logic [15:0] dq_sync1;
  logic [15:0] dq_sync2;

  // Address byte for cycle n in the active bus width
  function automatic logic [7:0] addr_byte(input nfh_req_s r, input logic [1:0] n);
    logic [27:0] a;
    a = '0;
    if (WORD_MODE) begin
      a = {1'h0, r.row, r.col[COL_W_X16-1:0]};  // [RULE12]
      case (n)
        2'h0: addr_byte = a[7:0];
        2'h1: addr_byte = {5'h0, a[10:8]};  // [RULE11]
        2'h2: addr_byte = a[18:11];
        default: addr_byte = a[26:19];
      endcase
    end else begin
      a = {r.row, r.col};  // [RULE10]
      case (n)
        2'h0: addr_byte = a[7:0];
        2'h1: addr_byte = {4'h0, a[11:8]};  // [RULE9]
        2'h2: addr_byte = a[19:12];
        default: addr_byte = a[27:20];
      endcase
    end
  endfunction

  nfh_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_req_valid),
    .i_in_data(i_req),
    .o_in_ready(o_req_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_req),
    .i_out_ready(fifo_ready)
  );

  // Accept a new request only when idle and the device is ready
  assign fifo_ready = (state == ST_IDLE) && rb_sync[1];

  // --------------------------------------------------------------
  // Pin input synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rb_sync <= 2'h0;
      dq_sync1 <= 16'h0;
      dq_sync2 <= 16'h0;
    end else begin
      rb_sync <= {rb_sync[0], i_ready_busy_n};  // [RULE8]
      dq_sync1 <= i_dq;
      dq_sync2 <= dq_sync1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b1;
    end else begin
      o_busy <= !rb_sync[1];  // [RULE8]
    end
  end

  // --------------------------------------------------------------
  // Strobe sequencer
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cur <= '0;
      timer <= 4'h0;
      addr_idx <= 2'h0;
      o_pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
      o_dq <= 16'h0;
      o_dq_oe <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0;
      o_col_error <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_pins.wp_n <= i_write_enable;  // [RULE7]
      case (state)
        ST_IDLE: begin
          if (fifo_valid && fifo_ready) begin
            cur <= fifo_req;
            addr_idx <= 2'h0;
            timer <= LOW_CNT;
            o_col_error <= (fifo_req.col >= (WORD_MODE ? COL_LIMIT_X16 : COL_LIMIT_X8));  // [RULE18]
            o_pins.ce_n <= 1'b0;
            o_pins.cle <= (fifo_req.op == NFH_OP_CMD);  // [RULE3]
            o_pins.ale <= (fifo_req.op == NFH_OP_ADDR);  // [RULE4]
            if (fifo_req.op == NFH_OP_READ) begin
              o_pins.re_n <= 1'b0;  // [RULE17]
              o_pins.we_n <= 1'b1;
              o_dq_oe <= 1'b0;
            end else begin
              o_pins.we_n <= 1'b0;
              o_dq_oe <= 1'b1;
              if (fifo_req.op == NFH_OP_ADDR) begin
                o_dq <= {8'h0, addr_byte(fifo_req, 2'h0)};  // [RULE16]
              end else if (fifo_req.op == NFH_OP_CMD) begin
                o_dq <= {8'h0, fifo_req.data[7:0]};  // [RULE16]
              end else begin
                o_dq <= WORD_MODE ? fifo_req.data : {8'h0, fifo_req.data[7:0]};
              end
            end
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (timer <= 4'h1) begin
            // Rising write strobe is the device's latch point
            o_pins.we_n <= 1'b1;  // [RULE1]
            if (cur.op == NFH_OP_READ) begin
              o_pins.re_n <= 1'b1;  // [RULE17]
            end
            timer <= HIGH_CNT;
            state <= ST_HIGH;
          end else begin
            timer <= timer - 4'h1;
          end
        end
        ST_HIGH: begin
          if (timer <= 4'h1) begin
            if (cur.op == NFH_OP_ADDR && addr_idx != ADDR_LAST) begin
              state <= ST_ADDR_NEXT;
            end else begin
              // Chip enable stays low; the device ignores it while busy anyway
              o_pins.cle <= 1'b0;
              o_pins.ale <= 1'b0;
              o_dq_oe <= 1'b0;
              state <= (cur.op == NFH_OP_READ) ? ST_CAPTURE : ST_IDLE;
            end
          end else begin
            timer <= timer - 4'h1;
          end
        end
        ST_CAPTURE: begin
          // DQ runs through two flops, so the value seen while the read strobe
          // was low only reaches the second stage now
          o_rd_data <= WORD_MODE ? dq_sync2 : {8'h0, dq_sync2[7:0]};  // [RULE17]
          o_rd_valid <= 1'b1;
          state <= ST_IDLE;
        end
        ST_ADDR_NEXT: begin
          addr_idx <= addr_idx + 2'h1;
          o_dq <= {8'h0, addr_byte(cur, addr_idx + 2'h1)};  // [RULE9]
          o_pins.we_n <= 1'b0;
          timer <= LOW_CNT;
          state <= ST_LOW;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_cmd_latch_cle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_pins.we_n) && cur.op == NFH_OP_CMD |-> o_pins.cle && !o_pins.ale)  // [RULE3]
    else $error("command strobe without command latch");
  a_addr_latch_ale: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_pins.we_n) && cur.op == NFH_OP_ADDR |-> o_pins.ale && !o_pins.cle)  // [RULE4]
    else $error("address strobe without address latch");
  a_read_pin_state: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_pins.re_n) |-> !o_pins.ce_n && o_pins.we_n && !o_pins.cle && !o_pins.ale)  // [RULE17]
    else $error("read strobe with bad control levels");
  a_low_byte_cmd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_pins.cle || o_pins.ale |-> o_dq[15:8] == 8'h0)  // [RULE16]
    else $error("command or address above low byte");
  a_dq_stable_edge: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_pins.we_n) |-> o_dq_oe && $stable(o_dq))  // [RULE1]
    else $error("data changed at write strobe rise");
  a_addr_upper_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_pins.we_n) && o_pins.ale && addr_idx == 2'h1 |->
      (WORD_MODE ? o_dq[7:3] == 5'h0 : o_dq[7:4] == 4'h0))  // [RULE9]
    else $error("second address cycle upper bits not zero");
  a_wp_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_write_enable |=> !o_pins.wp_n)  // [RULE7]
    else $error("write protect not applied");
  a_busy_no_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !rb_sync[1] && state == ST_IDLE |=> state == ST_IDLE)  // [RULE8]
    else $error("request started while device busy");
  a_rd_one_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_rd_valid |=> !o_rd_valid)  // [RULE6]
    else $error("read valid longer than one cycle");
endmodule

//--- verification/nfh_dev_model.sv
// Behavioural NAND flash device seen from the host pins
`timescale 1ns/100ps
module nfh_dev_model
  import nfh_pkg::*;
#(
  parameter int BUSY_NS = 1000
) (
  // Pins from host
  input wire nfh_pkg::nfh_pins_s i_pins,
  input wire logic [15:0] i_dq,
  // Pins to host
  output logic [15:0] o_dq,
  output logic o_rb_pull
);
  logic [7:0] mem [logic [27:0]];
  logic [7:0] pbuf [logic [11:0]];
  logic [7:0] cmd;
  logic [7:0] adr [4];
  logic [11:0] col;
  logic [7:0] last;
  logic drv;
  int na;
  initial begin
    cmd = 8'hff;
    col = '0;
    last = '0;
    drv = 1'b0;
    na = 0;
    o_rb_pull = 1'b0;
  end
  // ------------------------------
  // Strobed input
  // ------------------------------
  // No pull on DQ: released lines show the inverse of the last value
  assign o_dq = drv ? {8'h00, last} : ~{8'h00, last};
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && !o_rb_pull) begin
      if (i_pins.cle) begin
        cmd = i_dq[7:0];
        na = 0;
        if (cmd == 8'h80) pbuf.delete();
        if (cmd == 8'h10 && i_pins.wp_n) begin
          foreach (pbuf[c]) mem[{adr[3], adr[2], c}] = pbuf[c];
          o_rb_pull = 1'b1;
          // Busy ends by time alone; chip enable cannot cut it short
          o_rb_pull <= #(BUSY_NS) 1'b0;
        end
      end else if (i_pins.ale) begin
        adr[na[1:0]] = i_dq[7:0];
        na++;
        col = {adr[1][3:0], adr[0]};
      end else begin
        pbuf[col] = i_dq[7:0];
        col++;
      end
    end
  end
  always @(negedge i_pins.re_n) begin
    if (!i_pins.ce_n) begin
      last = mem.exists({adr[3], adr[2], col}) ? mem[{adr[3], adr[2], col}] : 8'hff;
      drv = 1'b1;
      col++;
    end
  end
  always @(posedge i_pins.re_n or posedge i_pins.ce_n) drv = 1'b0;
endmodule

//--- verification/tb_nfh_host.sv
// Self-checking bench for the NAND flash host controller
`timescale 1ns/100ps
module tb_nfh_host;
  import nfh_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_req_valid = 0, i_write_enable = 0, saw = 0;
  nfh_req_s i_req = '0;
  logic o_req_ready, o_rd_valid, o_busy, o_col_error, o_dq_oe, rb_pull;
  logic [15:0] o_rd_data, o_dq, dev_dq, i_dq;
  nfh_pins_s o_pins;
  logic o_col_error_w, o_dq_oe_w, rb_pull_w;
  logic [15:0] o_rd_data_w, o_dq_w, dev_dq_w, i_dq_w;
  nfh_pins_s o_pins_w;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  assign i_dq = o_dq_oe ? o_dq : dev_dq;
  nfh_host #(.WORD_MODE(1'b0), .FIFO_DEPTH(4)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .i_write_enable(i_write_enable), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_busy(o_busy), .o_col_error(o_col_error), .o_pins(o_pins), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .i_dq(i_dq), .i_ready_busy_n(~rb_pull));
  nfh_dev_model #(.BUSY_NS(1000)) dev (.i_pins(o_pins), .i_dq(i_dq), .o_dq(dev_dq),
    .o_rb_pull(rb_pull));
  // Word-wide twin fed the same requests; its own device keeps it in step
  assign i_dq_w = o_dq_oe_w ? o_dq_w : dev_dq_w;
  nfh_host #(.WORD_MODE(1'b1), .FIFO_DEPTH(4)) uut_w (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(),
    .i_write_enable(i_write_enable), .o_rd_valid(), .o_rd_data(o_rd_data_w),
    .o_busy(), .o_col_error(o_col_error_w), .o_pins(o_pins_w), .o_dq(o_dq_w),
    .o_dq_oe(o_dq_oe_w), .i_dq(i_dq_w), .i_ready_busy_n(~rb_pull_w));
  nfh_dev_model #(.BUSY_NS(1000)) dev_w (.i_pins(o_pins_w), .i_dq(i_dq_w), .o_dq(dev_dq_w),
    .o_rb_pull(rb_pull_w));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic push(nfh_op_e op, logic [15:0] d, logic [11:0] c, logic [15:0] r);
    int k;
    k = 0;
    tick(1);
    i_req = '{op, d, c, r};
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && k < 100) begin
      saw = 1'b1;
      tick(1);
      k++;
    end
    tick(1);
    i_req_valid = 1'b0;
  endtask
  task automatic cmd(logic [7:0] v);
    push(NFH_OP_CMD, {8'h00, v}, '0, '0);
  endtask
  task automatic wait_busy(logic lvl);
    int k;
    k = 0;
    while (o_busy !== lvl && k < 200) begin
      tick(1);
      k++;
    end
  endtask
  task automatic prog(logic [15:0] d0, logic [15:0] d1);
    cmd(8'h80);
    push(NFH_OP_ADDR, '0, 12'h000, 16'h0041);
    push(NFH_OP_WRITE, d0, '0, '0);
    push(NFH_OP_WRITE, d1, '0, '0);
    cmd(8'h10);
  endtask
  task automatic rd2(logic [15:0] e0, logic [15:0] e1);
    int k;
    cmd(8'h00);
    push(NFH_OP_ADDR, '0, 12'h000, 16'h0041);
    cmd(8'h30);
    for (int i = 0; i < 2; i++) begin
      push(NFH_OP_READ, '0, '0, '0);
      k = 0;
      while (o_rd_valid !== 1'b1 && k < 50) begin
        tick(1);
        k++;
      end
      chk("rd_data", i ? e1 : e0, o_rd_data);
      chk("rd_data_w", i ? e1 : e0, o_rd_data_w);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_addr();
    logic [7:0] exp [4] = '{8'h3f, 8'h08, 8'hcd, 8'hab};
    cmd(8'h90);
    push(NFH_OP_ADDR, '0, 12'h83f, 16'habcd);
    tick(40);
    chk("cmd", 16'h0090, {8'h00, dev.cmd});
    for (int i = 0; i < 4; i++) chk("addr", {8'h00, exp[i]}, {8'h00, dev.adr[i]});
    for (int i = 0; i < 4; i++) begin
      chk("addr_w", {8'h00, ((i == 1) ? 8'h00 : exp[i])}, {8'h00, dev_w.adr[i]});
    end
    chk("col_err", 16'h0000, {15'h0, o_col_error});
    chk("col_err_w", 16'h0001, {15'h0, o_col_error_w});
    push(NFH_OP_ADDR, '0, 12'h840, 16'h0001);
    tick(40);
    chk("col_err", 16'h0001, {15'h0, o_col_error});
    $display("done t_addr");
  endtask
  task automatic t_prog();
    i_write_enable = 1'b1;
    prog(16'h005a, 16'h00a5);
    wait_busy(1'b1);
    chk("busy", 16'h0001, {15'h0, o_busy});
    wait_busy(1'b0);
    rd2(16'h005a, 16'h00a5);
    $display("done t_prog");
  endtask
  task automatic t_protect();
    i_write_enable = 1'b0;
    tick(2);
    prog(16'h0033, 16'h0044);
    tick(60);
    rd2(16'h005a, 16'h00a5);
    $display("done t_protect");
  endtask
  task automatic t_fifo();
    saw = 1'b0;
    repeat (8) push(NFH_OP_ADDR, '0, 12'h001, 16'h0001);
    chk("refused", 16'h0001, {15'h0, saw});
    tick(120);
    chk("ready", 16'h0001, {15'h0, o_req_ready});
    $display("done t_fifo");
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    tick(2);
    chk("pins", 16'h0026, {10'h0, o_pins});
    chk("busy", 16'h0001, {15'h0, o_busy});
    chk("dq_oe", 16'h0000, {15'h0, o_dq_oe});
    $display("done t_reset");
    tick(1);
    i_rst = 1'b0;
    wait_busy(1'b0);
    t_addr();
    t_prog();
    t_protect();
    t_fifo();
    close_out();
  end
endmodule
